// ===== core/asc_pkg.sv
/*
 * Shared constants and types for the advertising and scan settings block.
 * Assumes a byte-wide command stream on the same clock as the core.
 */
package asc_pkg;
	// Frame framing
	localparam logic [7:0] FRAME_START  = 8'h02;
	localparam logic [7:0] SETTING_READ_REQUEST = 8'h10; // Get request code
	localparam logic [7:0] CMD_SET_REQ  = 8'h11;
	localparam logic [7:0] CONFIRM_BIT  = 8'h40;
	localparam logic [7:0] STATUS_OK    = 8'h00;
	localparam logic [7:0] STATUS_FAIL  = 8'h01;
	localparam logic [7:0] ZERO_BYTE    = 8'h00;
	localparam logic [2:0] HDR_BYTES    = 3'h5; // Start, cmd, two length, status
	localparam logic [2:0] PAY_KEEP     = 3'h3; // Payload bytes kept
	localparam logic [15:0] LEN_SET_WORD = 16'h0003; // Index plus two value bytes
	localparam logic [15:0] LEN_SET_BYTE = 16'h0002; // Index plus one value byte
	localparam logic [15:0] LEN_GET      = 16'h0001; // Index only
	// Settings indices
	localparam logic [7:0] IDX_ADV_TIMEOUT = 8'h07;
	localparam logic [7:0] IDX_SCAN_FACTOR = 8'h0A;
	localparam logic [7:0] IDX_ADV_FLAGS   = 8'h1D;
	// Value limits and reset values
	localparam logic [15:0] TIMEOUT_MAX    = 16'h028A; // 650 s
	localparam logic [15:0] TIMEOUT_RESET  = 16'h0000;
	localparam logic [7:0]  FACTOR_MIN     = 8'h01;
	localparam logic [7:0]  FACTOR_MAX     = 8'h0A;
	localparam logic [7:0]  FACTOR_RESET   = 8'h02;
	localparam logic [7:0]  FLAGS_MAX      = 8'h01;
	localparam logic [7:0]  FLAGS_RESET    = 8'h00;
	localparam int          FLAG_SAME_BIT  = 0;
	// Timing
	localparam int CLK_MHZ        = 100;
	localparam int SCAN_WINDOW_MS = 50;
	localparam int SCAN_WINDOW_CYC = SCAN_WINDOW_MS * 1000 * CLK_MHZ;
	localparam int SECOND_CYC     = 1000 * 1000 * CLK_MHZ;
	localparam logic [1:0] CHANNELS_LAST = 2'h2; // Three scan channels
	// Receive and answer sequencer, Gray along the usual path
	typedef enum logic [2:0] {
		ST_START = 3'h0,
		ST_CMD   = 3'h1,
		ST_LENL  = 3'h3,
		ST_LENH  = 3'h2,
		ST_PAY   = 3'h6,
		ST_SUM   = 3'h7,
		ST_TX    = 3'h5
	} asc_state_e;
	// Advertising packet content choice
	typedef enum logic [1:0] {
		ADV_NAME5_TXPWR = 2'h0, // Configured name, 5 bytes, plus power
		ADV_ADDR_NAME8  = 2'h1, // Name made from hardware_radio_address
		ADV_CFG_NAME8   = 2'h2  // Configured name, 8 bytes
	} asc_adv_e;
	// Stored settings
	typedef struct packed {
		logic [15:0] advertising_timeout_seconds;
		logic [7:0]  scan_interval_factor;
		logic [7:0]  advertising_content_flags;
	} asc_settings_s;
endpackage

// ===== core/asc_core.sv
/*
 * Command interpreter for advertising timeout, advertising content flags
 * and scan factor, with advertising timer and scan duty sequencer.
 * Assumes rx and tx byte streams from logic on the same clock.
 */
// Functional notes
// - Nonzero timeout counts whole seconds, 1..650
// - Timeout without peer: stop, enter system-off
// - Zero timeout advertises forever; default zero
// - Advertising timeout uses settings index 7
// - Flag clear, command mode: 5-byte name, power
// - Flag clear, peripheral-only: address name only
// - Flag set: 8-byte configured name always
// - Flags use index 29; 1 unifies content
// - Scan factor 1..10, default 2, interval ratio
// - Listen window, suspend factor-1 windows, switch
// - Scan factor uses settings index 10
`timescale 1ns/1ns
module asc_core #(
	parameter int SEC_CYC = asc_pkg::SECOND_CYC,     // Cycles per second
	parameter int WIN_CYC = asc_pkg::SCAN_WINDOW_CYC // Cycles per scan window
) (
	input  wire logic                   clk,            // Clock, 100 MHz
	input  wire logic                   arst_n,         // Async reset, low
	input  wire logic                   ce,             // Clock enable
	input  wire logic                   rx_valid,       // Request byte valid
	input  wire logic [7:0]             rx_data,        // Request byte
	output logic                        rx_ready,       // Byte taken
	output logic                        tx_valid,       // Answer byte valid
	output logic [7:0]                  tx_data,        // Answer byte
	input  wire logic                   tx_ready,       // Answer byte taken
	input  wire logic                   adv_start,      // Begin advertising
	input  wire logic                   peer_connected, // Peer has connected
	input  wire logic                   peripheral_only_mode, // Mode select
	input  wire logic                   scan_enable,    // Scanning wanted
	output logic                        advertising,    // Advertising active
	output logic                        system_off,     // Low power state
	output asc_pkg::asc_adv_e           adv_content,    // Packet content
	output logic                        scan_listen,    // Radio listening
	output logic                        channel_switch, // Channel step pulse
	output logic [1:0]                  scan_channel,   // Current channel
	output asc_pkg::asc_settings_s      settings        // Stored settings
);
	// Sequencer state
	asc_pkg::asc_state_e   st_q;       // Current state
	logic [7:0]            cmd_q;      // Request command
	logic [15:0]           len_q;      // Payload length
	logic [15:0]           cnt_q;      // Payload bytes seen
	logic [7:0]            rcs_q;      // Running receive checksum
	logic [7:0]            pay_q [3];  // First payload bytes
	asc_pkg::asc_settings_s set_q;     // Settings store
	// Answer state
	logic [7:0]            rsp_cmd_q;  // Answer code
	logic [7:0]            rsp_st_q;   // Answer status
	logic [15:0]           rsp_val_q;  // Answer value
	logic [1:0]            rsp_n_q;    // Value bytes in answer
	logic [2:0]            tidx_q;     // Index of byte on tx_data
	logic [7:0]            tcs_q;      // Checksum of bytes already sent
	logic [7:0]            tdat_q;     // Byte on tx_data
	// Advertising timer state
	logic                  adv_q;      // Advertising
	logic                  off_q;      // System off
	logic [31:0]           pre_q;      // Second prescaler
	logic [15:0]           secs_q;     // Elapsed seconds
	// Scan sequencer state
	logic [31:0]           wcyc_q;     // Cycle within window
	logic [7:0]            widx_q;     // Window within interval
	logic [1:0]            chan_q;     // Scan channel
	logic                  sw_q;       // Channel switch pulse

	// Byte handshake decode
	// Requests are refused while an answer goes out, so a host
	// that keeps sending simply stalls until the answer ends.
	// An answer byte moves on only when the host accepts it.
	wire rx_take  = ce && rx_valid && st_q != asc_pkg::ST_TX;
	wire tx_take  = ce && tx_ready && st_q == asc_pkg::ST_TX;
	wire [7:0] rcs_next = rcs_q ^ rx_data;
	wire [15:0] len_full = {rx_data, len_q[7:0]};
	wire pay_last = cnt_q + 16'h0001 == len_q;

	// Request decode on the checksum byte
	// Only the first three payload bytes are kept; a length that does
	// not match the setting's width is refused with a failure status.
	wire is_get = cmd_q == asc_pkg::SETTING_READ_REQUEST;
	wire is_set = cmd_q == asc_pkg::CMD_SET_REQ;
	wire [7:0] idx = pay_q[0];
	wire [15:0] v16 = {pay_q[2], pay_q[1]};
	wire [7:0] v8 = pay_q[1];
	wire hit_to = idx == asc_pkg::IDX_ADV_TIMEOUT;
	wire hit_sf = idx == asc_pkg::IDX_SCAN_FACTOR;
	wire hit_fl = idx == asc_pkg::IDX_ADV_FLAGS;
	wire ok_to = hit_to && len_q == asc_pkg::LEN_SET_WORD && v16 <= asc_pkg::TIMEOUT_MAX;
	wire ok_sf = hit_sf && len_q == asc_pkg::LEN_SET_BYTE && v8 >= asc_pkg::FACTOR_MIN
		&& v8 <= asc_pkg::FACTOR_MAX;
	wire ok_fl = hit_fl && len_q == asc_pkg::LEN_SET_BYTE && v8 <= asc_pkg::FLAGS_MAX;
	wire get_ok = is_get && len_q == asc_pkg::LEN_GET && (hit_to || hit_sf || hit_fl);
	wire set_ok = is_set && (ok_to || ok_sf || ok_fl);
	// A bad checksum drops the frame without any answer
	wire sum_ok = rx_take && st_q == asc_pkg::ST_SUM && rx_data == rcs_q;
	wire answer = sum_ok && (is_get || is_set);
	wire good = is_get ? get_ok : set_ok;
	wire [15:0] get_val = hit_to ? set_q.advertising_timeout_seconds
		: hit_sf ? {8'h00, set_q.scan_interval_factor}
		: {8'h00, set_q.advertising_content_flags};
	wire [1:0] get_n = hit_to ? 2'h2 : 2'h1;

	// Answer byte selection for the next index
	// Byte order: start, code, length low, length high, status,
	// value low, value high, checksum; value bytes only on reads.
	wire [2:0] tnext = tidx_q + 3'h1;
	wire [2:0] tlast = asc_pkg::HDR_BYTES + {1'b0, rsp_n_q};
	wire [7:0] tcs_next = tcs_q ^ tdat_q;
	wire [7:0] val_byte = tnext == asc_pkg::HDR_BYTES ? rsp_val_q[7:0]
		: rsp_val_q[15:8];
	wire [7:0] tsel = tnext == 3'h1 ? rsp_cmd_q
		: tnext == 3'h2 ? 8'h01 + {6'h00, rsp_n_q}
		: tnext == 3'h3 ? asc_pkg::ZERO_BYTE
		: tnext == 3'h4 ? rsp_st_q
		: tnext == tlast ? tcs_next : val_byte;

	// Handshake outputs are decoded straight from the state
	assign rx_ready = st_q != asc_pkg::ST_TX;
	assign tx_valid = st_q == asc_pkg::ST_TX;
	assign tx_data  = tdat_q;
	assign settings = set_q;

	// Next state of the request and answer sequencer
	// Bytes that do not open a frame are dropped while idle;
	// an answer only follows a set or get with a good checksum.
	asc_pkg::asc_state_e st_d;
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			asc_pkg::ST_START: if (rx_take && rx_data == asc_pkg::FRAME_START) begin
				st_d = asc_pkg::ST_CMD;
			end
			asc_pkg::ST_CMD:  if (rx_take) st_d = asc_pkg::ST_LENL;
			asc_pkg::ST_LENL: if (rx_take) st_d = asc_pkg::ST_LENH;
			asc_pkg::ST_LENH: if (rx_take) begin
				st_d = len_full == 16'h0000 ? asc_pkg::ST_SUM : asc_pkg::ST_PAY;
			end
			asc_pkg::ST_PAY:  if (rx_take && pay_last) st_d = asc_pkg::ST_SUM;
			asc_pkg::ST_SUM:  if (rx_take) begin
				st_d = answer ? asc_pkg::ST_TX : asc_pkg::ST_START;
			end
			asc_pkg::ST_TX:   if (tx_take && tidx_q == tlast) st_d = asc_pkg::ST_START;
			default:          st_d = asc_pkg::ST_START;
		endcase
	end

	// Frame capture
	// The running checksum restarts on the start byte; the checksum
	// byte must equal the XOR of everything before it.
	// Length arrives low byte first.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q   <= asc_pkg::ST_START;
			cmd_q  <= 8'h00;
			len_q  <= 16'h0000;
			cnt_q  <= 16'h0000;
			rcs_q  <= 8'h00;
			pay_q  <= '{default: 8'h00};
		end else if (ce) begin
			st_q <= st_d;
			if (rx_take) begin
				rcs_q <= rcs_next;
				if (st_q == asc_pkg::ST_START) rcs_q <= rx_data;
				if (st_q == asc_pkg::ST_CMD)   cmd_q <= rx_data;
				if (st_q == asc_pkg::ST_LENL)  len_q <= {8'h00, rx_data};
				if (st_q == asc_pkg::ST_LENH)  len_q <= len_full;
				if (st_q == asc_pkg::ST_LENH)  cnt_q <= 16'h0000;
				if (st_q == asc_pkg::ST_PAY)   cnt_q <= cnt_q + 16'h0001;
				if (st_q == asc_pkg::ST_PAY && cnt_q < {13'h0, asc_pkg::PAY_KEEP}) begin
					pay_q[cnt_q[1:0]] <= rx_data;
				end
			end
		end
	end

	// Settings store, written by accepted set requests
	// A refused value leaves the stored setting as it was.
	// Reset values: no timeout, factor two, flags clear.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			set_q.advertising_timeout_seconds <= asc_pkg::TIMEOUT_RESET;
			set_q.scan_interval_factor        <= asc_pkg::FACTOR_RESET;
			set_q.advertising_content_flags   <= asc_pkg::FLAGS_RESET;
		end else if (ce && answer && set_ok) begin
			if (ok_to) set_q.advertising_timeout_seconds <= v16;
			if (ok_sf) set_q.scan_interval_factor <= v8;
			if (ok_fl) set_q.advertising_content_flags <= v8;
		end
	end

	// Answer framing and byte output
	// The start byte is loaded when the request is accepted; each
	// accepted answer byte then loads the one after it.
	// A failed request answers with status only, no value bytes.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rsp_cmd_q <= 8'h00;
			rsp_st_q  <= 8'h00;
			rsp_val_q <= 16'h0000;
			rsp_n_q   <= 2'h0;
			tidx_q    <= 3'h0;
			tcs_q     <= 8'h00;
			tdat_q    <= 8'h00;
		end else if (ce) begin
			if (answer) begin
				rsp_cmd_q <= cmd_q | asc_pkg::CONFIRM_BIT;
				rsp_st_q  <= good ? asc_pkg::STATUS_OK : asc_pkg::STATUS_FAIL;
				rsp_val_q <= get_val;
				rsp_n_q   <= is_get && good ? get_n : 2'h0;
				tidx_q    <= 3'h0;
				tcs_q     <= 8'h00;
				tdat_q    <= asc_pkg::FRAME_START;
			end else if (tx_take) begin
				tidx_q <= tnext;
				tcs_q  <= tcs_next;
				tdat_q <= tsel;
			end
		end
	end

	// Advertising timer and power-down
	// The prescaler only runs while a nonzero timeout is armed;
	// a zero timeout therefore leaves advertising up forever.
	// Expiry compares whole elapsed seconds with the setting.
	wire to_zero = set_q.advertising_timeout_seconds == 16'h0000;
	wire sec_tick = pre_q == SEC_CYC - 1;
	wire expired = !to_zero && secs_q == set_q.advertising_timeout_seconds;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			adv_q  <= 1'b0;
			off_q  <= 1'b0;
			pre_q  <= 32'h0;
			secs_q <= 16'h0000;
		end else if (ce) begin
			// A due power-down beats a restart in the same cycle
			if (adv_q && expired && !peer_connected) begin
				adv_q <= 1'b0;
				off_q <= 1'b1;
			end else if (adv_start) begin
				adv_q  <= 1'b1;
				off_q  <= 1'b0;
				pre_q  <= 32'h0;
				secs_q <= 16'h0000;
			end else if (adv_q && peer_connected) begin
				adv_q <= 1'b0; // Peer stops it, no power-down
			end else if (adv_q && !to_zero) begin
				pre_q <= sec_tick ? 32'h0 : pre_q + 32'h1;
				if (sec_tick) secs_q <= secs_q + 16'h0001;
			end
		end
	end
	assign advertising = adv_q;
	assign system_off  = off_q;

	// Advertising packet content selection
	// Flag bit 0 set gives every mode the same packet; with it clear,
	// command mode adds the power level and peripheral-only mode
	// sends the name made from the hardware address.
	wire same_all = set_q.advertising_content_flags[asc_pkg::FLAG_SAME_BIT];
	assign adv_content = same_all ? asc_pkg::ADV_CFG_NAME8
		: peripheral_only_mode ? asc_pkg::ADV_ADDR_NAME8
		: asc_pkg::ADV_NAME5_TXPWR;

	// Scan duty cycle: one listening window, factor-1 suspended windows
	// Listening is window zero of each interval.
	// Disabling scan restarts the interval; the channel is kept.
	wire win_end = wcyc_q == WIN_CYC - 1;
	wire int_end = widx_q + 8'h01 >= set_q.scan_interval_factor;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wcyc_q <= 32'h0;
			widx_q <= 8'h00;
			chan_q <= 2'h0;
			sw_q   <= 1'b0;
		end else if (ce) begin
			sw_q <= 1'b0;
			if (!scan_enable) begin
				wcyc_q <= 32'h0;
				widx_q <= 8'h00;
			end else if (win_end) begin
				wcyc_q <= 32'h0;
				widx_q <= int_end ? 8'h00 : widx_q + 8'h01;
				if (int_end) begin
					sw_q   <= 1'b1;
					chan_q <= chan_q == asc_pkg::CHANNELS_LAST ? 2'h0 : chan_q + 2'h1;
				end
			end else begin
				wcyc_q <= wcyc_q + 32'h1;
			end
		end
	end
	assign scan_listen    = scan_enable && widx_q == 8'h00;
	assign channel_switch = sw_q;
	assign scan_channel   = chan_q;
endmodule

// ===== verification/asc_properties.sv
/* Port checker for the settings block.
   Assumes one clock, async low reset, bound to asc_core. */
`timescale 1ns/1ns
module asc_properties (
	input wire logic                   clk,            // Clock
	input wire logic                   arst_n,         // Reset, low
	input wire logic                   ce,             // Clock enable
	input wire logic                   rx_ready,       // Byte taken
	input wire logic                   tx_valid,       // Answer valid
	input wire logic [7:0]             tx_data,        // Answer byte
	input wire logic                   tx_ready,       // Answer taken
	input wire logic                   adv_start,      // Advertise
	input wire logic                   peer_connected, // Peer in
	input wire logic                   peripheral_only_mode, // Mode
	input wire logic                   scan_enable,    // Scan wanted
	input wire logic                   advertising,    // Advertising
	input wire logic                   system_off,     // Low power
	input wire asc_pkg::asc_adv_e      adv_content,    // Content
	input wire logic                   scan_listen,    // Listening
	input wire logic                   channel_switch, // Step pulse
	input wire logic [1:0]             scan_channel,   // Channel
	input wire asc_pkg::asc_settings_s settings        // Settings
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	tx_hold_a: assert property (tx_valid && !tx_ready && ce |=> tx_valid && $stable(tx_data))
		else $error("answer byte not held");
	rx_block_a: assert property (tx_valid |-> !rx_ready)
		else $error("request taken while answering");
	ans_start_a: assert property ($rose(tx_valid) |-> tx_data == asc_pkg::FRAME_START)
		else $error("answer lacks start byte");
	timeout_max_a: assert property (settings.advertising_timeout_seconds <= 16'h028A)
		else $error("timeout out of range");
	factor_range_a: assert property (settings.scan_interval_factor inside {[1:10]})
		else $error("scan factor out of range");
	adv_content_a: assert property (adv_content == (settings.advertising_content_flags[0] ?
		asc_pkg::ADV_CFG_NAME8 : peripheral_only_mode ? asc_pkg::ADV_ADDR_NAME8 :
		asc_pkg::ADV_NAME5_TXPWR)) else $error("wrong packet content");
	off_cause_a: assert property ($rose(system_off) |->
		!advertising && $past(settings.advertising_timeout_seconds) != 16'h0000)
		else $error("bad system off");
	peer_stop_a: assert property (peer_connected && !adv_start |=> !advertising && !$rose(system_off))
		else $error("peer did not stop advertising");
	switch_once_a: assert property (channel_switch |=> !channel_switch)
		else $error("switch pulse too long");
	chan_step_a: assert property (channel_switch |-> scan_channel ==
		($past(scan_channel) == 2'h2 ? 2'h0 : $past(scan_channel) + 2'h1))
		else $error("channel did not step");
	scan_idle_a: assert property (!scan_enable |-> !scan_listen)
		else $error("listening while scan off");
	scan_start_a: assert property ($rose(scan_enable) |-> scan_listen)
		else $error("scan did not start listening");
	zero_forever_a: assert property (ce && advertising && !peer_connected &&
		settings.advertising_timeout_seconds == 16'h0000 |=> advertising)
		else $error("advertising stopped with zero timeout");
endmodule
bind asc_core asc_properties u_props (.clk(clk), .arst_n(arst_n), .ce(ce), .rx_ready(rx_ready),
	.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .adv_start(adv_start),
	.peer_connected(peer_connected), .peripheral_only_mode(peripheral_only_mode),
	.scan_enable(scan_enable), .advertising(advertising), .system_off(system_off),
	.adv_content(adv_content), .scan_listen(scan_listen), .channel_switch(channel_switch),
	.scan_channel(scan_channel), .settings(settings));

// ===== verification/asc_host.sv
/* Host model: sends request frames, collects answer bytes.
   Assumes the core clock; drives at the falling edge. */
`timescale 1ns/1ns
module asc_host (
	input  wire logic       clk,      // Core clock
	output logic            rx_valid, // Request valid
	output logic [7:0]      rx_data,  // Request byte
	input  wire logic       rx_ready, // Byte taken
	input  wire logic       tx_valid, // Answer valid
	input  wire logic [7:0] tx_data,  // Answer byte
	output logic            tx_ready  // Answer taken
);
	logic       slow = 1'b0; // Stall answers
	logic [7:0] ans [$];     // Answer bytes seen
	initial begin
		rx_valid = 1'b0;
		rx_data  = 8'hFF;
		tx_ready = 1'b0;
	end
	// One byte, held until taken, then scrambled
	task put(input logic [7:0] b);
		@(negedge clk);
		rx_valid = 1'b1;
		rx_data  = b;
		do @(posedge clk); while (!rx_ready);
		@(negedge clk);
		rx_valid = 1'b0;
		rx_data  = ~b;
	endtask
	// Whole frame with XOR checksum, values low byte first
	task frame(input logic [7:0] cmd, idx, input logic [15:0] v, input int n);
		logic [7:0] f [$];
		logic [7:0] cs;
		f = {8'h02, cmd, n[7:0], 8'h00, idx, v[7:0], v[15:8]};
		f = f[0:n+3];
		cs = 8'h00;
		foreach (f[i]) cs ^= f[i];
		foreach (f[i]) put(f[i]);
		put(cs);
	endtask
	// Stall every other cycle when slow
	always @(negedge clk) tx_ready <= slow ? ~tx_ready : 1'b1;
	always @(posedge clk) if (tx_valid && tx_ready) ans.push_back(tx_data);
endmodule

// ===== verification/advertising_scan_settings_test.sv
/* Testbench for asc_core with host model.
   Assumes short second and window counts set below. */
`timescale 1ns/1ns
module advertising_scan_settings_test;
	localparam logic [7:0] SET = asc_pkg::CMD_SET_REQ, GET = asc_pkg::SETTING_READ_REQUEST;
	localparam logic [7:0] OK = 8'h00, FL = 8'h01;
	logic clk = 1'b0, arst_n, rx_valid, rx_ready, tx_valid, tx_ready, adv_start;
	logic peer_connected, peripheral_only_mode, scan_enable, advertising;
	logic system_off, scan_listen, channel_switch;
	logic [7:0] rx_data, tx_data;
	logic [1:0] scan_channel;
	logic [1:0] ch;
	asc_pkg::asc_adv_e adv_content;
	asc_pkg::asc_settings_s settings;
	logic [31:0] seed = 32'hC612;
	logic [15:0] tv, fv;
	int errors = 0, checks = 0, cyc = 0, t, c;
	logic [7:0] bad_i [4] = '{8'h07, 8'h0A, 8'h0A, 8'h1D};
	logic [15:0] bad_v [4] = '{16'h028B, 16'h0000, 16'h000B, 16'h0002};
	int bad_n [4] = '{3, 2, 2, 2};
	logic [7:0] bad_cs [7] = '{8'h02, 8'h11, 8'h02, 8'h00, 8'h0A, 8'h05, 8'h00};
	always #5 clk = ~clk;
	asc_core #(.SEC_CYC(4), .WIN_CYC(3)) u_dut (.clk(clk), .arst_n(arst_n), .ce(1'b1),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .adv_start(adv_start),
		.peer_connected(peer_connected), .peripheral_only_mode(peripheral_only_mode),
		.scan_enable(scan_enable), .advertising(advertising), .system_off(system_off),
		.adv_content(adv_content), .scan_listen(scan_listen), .channel_switch(channel_switch),
		.scan_channel(scan_channel), .settings(settings));
	asc_host u_host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function asc_pkg::asc_adv_e want(input logic f, p);
		return f ? asc_pkg::ADV_CFG_NAME8 : p ? asc_pkg::ADV_ADDR_NAME8 : asc_pkg::ADV_NAME5_TXPWR;
	endfunction
	task check(input logic [15:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task test_done();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Send one request; v is the value sent or the value expected back
	task xact(input logic [7:0] cmd, idx, input logic [15:0] v, input int n,
		input logic [7:0] st, input int vn);
		logic [7:0] e [$];
		logic [7:0] cs;
		int w;
		u_host.ans = {};
		u_host.frame(cmd, idx, v, n);
		e = {8'h02, cmd | asc_pkg::CONFIRM_BIT, 8'(vn + 1), 8'h00, st, v[7:0], v[15:8]};
		e = e[0:4+vn];
		cs = 8'h00;
		foreach (e[i]) cs ^= e[i];
		e.push_back(cs);
		for (w = 0; w < 60 && u_host.ans.size() < e.size(); w++) @(posedge clk);
		foreach (e[i]) check(16'(u_host.ans[i]), 16'(e[i]));
	endtask
	// Watchdog
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			test_done();
		end
	end
	initial begin
		{arst_n, adv_start, peer_connected, peripheral_only_mode, scan_enable} = '0;
		repeat (6) @(negedge clk);
		arst_n = 1'b1;
		check(settings.advertising_timeout_seconds, 16'h0000);
		check(16'(settings.scan_interval_factor), 16'h0002);
		check(16'(settings.advertising_content_flags), 16'h0000);
		for (int k = 0; k < 6; k++) begin
			seed = lfsr(seed);
			u_host.slow = k[0];
			tv = 16'(seed[15:0] % 650 + 1);
			fv = 16'(seed[19:16] % 10 + 1);
			xact(SET, 8'h07, tv, 3, OK, 0);
			xact(GET, 8'h07, tv, 1, OK, 2);
			xact(SET, 8'h0A, fv, 2, OK, 0);
			xact(GET, 8'h0A, fv, 1, OK, 1);
			xact(SET, 8'h1D, 16'(k % 2), 2, OK, 0);
			xact(GET, 8'h1D, 16'(k % 2), 1, OK, 1);
			for (int p = 0; p < 2; p++) begin
				@(negedge clk) peripheral_only_mode = p[0];
				#1 check(16'(adv_content), 16'(want(k[0], p[0])));
			end
		end
		xact(SET, 8'h07, 16'h028A, 3, OK, 0);
		foreach (bad_i[j]) xact(SET, bad_i[j], bad_v[j], bad_n[j], FL, 0);
		xact(GET, 8'h07, 16'h028A, 1, OK, 2);
		xact(GET, 8'h0A, fv, 1, OK, 1);
		xact(GET, 8'h09, 16'h0000, 1, FL, 0);
		// Scan duty with factor 3
		xact(SET, 8'h0A, 16'h0003, 2, OK, 0);
		@(negedge clk) scan_enable = 1'b1;
		for (t = 0; t < 99 && !channel_switch; t++) @(negedge clk);
		ch = scan_channel;
		c = 0;
		t = 0;
		do begin
			@(negedge clk);
			t++;
			c += scan_listen;
		end while (!channel_switch && t < 99);
		check(16'(t), 16'h0009);
		check(16'(c), 16'h0003);
		check(16'(scan_channel), 16'(ch == 2'h2 ? 2'h0 : ch + 2'h1));
		// Bad checksum: frame dropped, no answer, factor kept
		u_host.ans = {};
		foreach (bad_cs[j]) u_host.put(bad_cs[j]);
		repeat (12) @(negedge clk);
		check(16'(u_host.ans.size()), 16'h0000);
		check(16'(settings.scan_interval_factor), 16'h0003);
		// Advertising stops after two seconds
		xact(SET, 8'h07, 16'h0002, 3, OK, 0);
		@(negedge clk) adv_start = 1'b1;
		@(negedge clk) adv_start = 1'b0;
		for (t = 1; t < 40 && !system_off; t++) @(negedge clk);
		// Two seconds of four cycles, the expiry edge, and the loop start
		check(16'(t), 16'h000A);
		check(16'(advertising), 16'h0000);
		// Zero timeout never expires, peer stops it
		xact(SET, 8'h07, 16'h0000, 3, OK, 0);
		@(negedge clk) adv_start = 1'b1;
		@(negedge clk) adv_start = 1'b0;
		repeat (30) @(negedge clk);
		check(16'({advertising, system_off}), 16'h0002);
		peer_connected = 1'b1;
		@(negedge clk) peer_connected = 1'b0;
		check(16'({advertising, system_off}), 16'h0000);
		// Beacon host: flag bit 0 cleared keeps the power level in
		xact(SET, 8'h1D, 16'h0000, 2, OK, 0);
		@(negedge clk) peripheral_only_mode = 1'b0;
		#1 check(16'(adv_content), 16'(asc_pkg::ADV_NAME5_TXPWR));
		test_done();
	end
endmodule
